// *** common/sdrmb_consts.vh ***
`ifndef SDRMB_CONSTS_VH
`define SDRMB_CONSTS_VH

// ==========================================================================
// Mode opcode word field positions
`define SDRMB_BL_LSB      0
`define SDRMB_BL_MSB      2
`define SDRMB_BT_BIT      3
`define SDRMB_CL_LSB      4
`define SDRMB_CL_MSB      6
`define SDRMB_WM_LSB      9
`define SDRMB_WM_MSB      11

// ==========================================================================
// Field codes
`define SDRMB_BL_1        3'h0
`define SDRMB_BL_2        3'h1
`define SDRMB_BL_4        3'h2
`define SDRMB_BL_8        3'h3
`define SDRMB_BL_FP       3'h7
`define SDRMB_CL_2        3'h2
`define SDRMB_CL_3        3'h3
`define SDRMB_WM_BURST    3'h0
`define SDRMB_WM_SINGLE   3'h4
`define SDRMB_MODE_RST    12'h020

// ==========================================================================
// Command codes as {ras_n, cas_n, we_n}
`define SDRMB_CMD_MODE    3'h0
`define SDRMB_CMD_ACT     3'h3
`define SDRMB_CMD_READ    3'h5
`define SDRMB_CMD_WRITE   3'h4
`define SDRMB_CMD_PRE     3'h2
`define SDRMB_CMD_STOP    3'h6

// ==========================================================================
// Address bit positions
`define SDRMB_A_TEN       10
`define SDRMB_A_ELEVEN    11
`define SDRMB_COL_MSB     7

// ==========================================================================
// Register offsets and reset values
`define SDRMB_REG_CTRL    8'h00
`define SDRMB_REG_MODE    8'h04
`define SDRMB_REG_STAT    8'h08
`define SDRMB_REG_DROP    8'h0C
`define SDRMB_CTRL_RST    1'h0
`define SDRMB_DROP_RST    16'h0000

`endif

// *** src/sdrmb_fifo.v ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Write buffer FIFO
module sdrmb_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  // Honest full and empty from the count
  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = store[rd_ptr];

  // Storage write
  always @(posedge clk)
  begin
    if (push)
      store[wr_ptr] <= in_data;
  end

  // Pointers and occupancy
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

endmodule
`default_nettype wire

// *** src/sdrmb_burst_col.v ***
`timescale 1ns/1ps
`default_nettype none

`include "sdrmb_consts.vh"

// ==========================================================================
// Column of one burst step
module sdrmb_burst_col (
  input  wire [7:0] start,
  input  wire [7:0] step,
  input  wire [2:0] size_code,
  input  wire       interleave,
  output wire [7:0] col
);

  reg [7:0] mask;

  // Bits that move inside the burst block
  always @*
  begin
    case (size_code)
      `SDRMB_BL_2:  mask = 8'h01;
      `SDRMB_BL_4:  mask = 8'h03;
      `SDRMB_BL_8:  mask = 8'h07;
      `SDRMB_BL_FP: mask = 8'hFF;
      default:      mask = 8'h00;
    endcase
  end

  wire [7:0] seq_low = start + step;
  wire [7:0] ilv_low = start ^ step;

  // Upper bits held, low bits wrap within block
  assign col = (start & ~mask) | ((interleave ? ilv_low : seq_low) & mask);

endmodule
`default_nettype wire

// *** src/sdrmb_top.v ***
// How it works
// - First read word appears the programmed latency after the read command.
// - Latency field bits 6..4: code 2 gives two cycles, 3 gives three.
// - Burst starts at the given column; later columns are generated inside.
// - Burst size field bits 2..0: 1, 2, 4, 8 words or full page.
// - Full page runs 256 columns with wrap until the controller stops it.
// - Order bit 3: zero sequential, one interleaved.
// - Sequential order counts the low column bits modulo burst size.
// - Write mode 000 makes writes follow the burst size.
// - First write word is taken on the write command edge.
// - Write mode 100 stores one word per write; reads still burst.
// - Precharge with bit ten low closes one bank; high closes both.
// - Bit eleven picks the bank for activate and precharge; row from 10..0.
// - Bit eleven picks the bank for read and write; column from 7..0.
// - Bit ten on read or write closes the bank after the burst; in full page it is ignored and the bank stays open.
// - Address bits 8 and 9 are ignored on read and write.
// - Mode load takes all twelve address bits as the opcode word.
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

`include "sdrmb_consts.vh"

module sdrmb_top #(
  parameter ROW_BITS   = 11,
  parameter DATA_W     = 16,
  parameter FIFO_DEPTH = 16
) (
  input  wire              CLK,
  input  wire              RST,
  input  wire              CS_N,
  input  wire              RAS_N,
  input  wire              CAS_N,
  input  wire              WE_N,
  input  wire [11:0]       ADDR,
  input  wire [DATA_W-1:0] DQ_IN,
  output reg  [DATA_W-1:0] DQ_OUT,
  output reg               DQ_OE,
  output wire              WBUF_READY,
  input  wire              HSEL,
  input  wire [31:0]       HADDR,
  input  wire [1:0]        HTRANS,
  input  wire              HWRITE,
  input  wire [2:0]        HSIZE,
  input  wire [31:0]       HWDATA,
  input  wire              HREADY,
  output reg  [31:0]       HRDATA,
  output wire              HREADYOUT,
  output wire              HRESP
);

  // ========================================================================
  // Sizes
  localparam COL_BITS = 8;
  localparam MEM_AW   = 1 + ROW_BITS + COL_BITS;
  localparam ENT_W    = MEM_AW + DATA_W;

  // ========================================================================
  // Command decode
  wire [2:0] cmd      = {RAS_N, CAS_N, WE_N};
  wire       cmd_mode = !CS_N && (cmd == `SDRMB_CMD_MODE);
  wire       cmd_act  = !CS_N && (cmd == `SDRMB_CMD_ACT);
  wire       cmd_read = !CS_N && (cmd == `SDRMB_CMD_READ);
  wire       cmd_wr   = !CS_N && (cmd == `SDRMB_CMD_WRITE);
  wire       cmd_pre  = !CS_N && (cmd == `SDRMB_CMD_PRE);
  wire       cmd_stop = !CS_N && (cmd == `SDRMB_CMD_STOP);
  wire       cmd_rw   = cmd_read || cmd_wr;

  // Address fields of the current command
  wire       a_bank   = ADDR[`SDRMB_A_ELEVEN];
  wire       a_ten    = ADDR[`SDRMB_A_TEN];
  wire [7:0] a_col    = ADDR[`SDRMB_COL_MSB:0];

  // ========================================================================
  // Mode opcode word and its fields
  reg  [11:0] mode_word;
  wire [2:0]  size_code  = mode_word[`SDRMB_BL_MSB:`SDRMB_BL_LSB];
  wire        interleave = mode_word[`SDRMB_BT_BIT];
  wire [2:0]  lat_code   = mode_word[`SDRMB_CL_MSB:`SDRMB_CL_LSB];
  wire        lat3       = (lat_code == `SDRMB_CL_3);
  wire        single_wr  = (mode_word[`SDRMB_WM_MSB:`SDRMB_WM_LSB] == `SDRMB_WM_SINGLE);

  // Mode load captures the whole address bus
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
      mode_word <= `SDRMB_MODE_RST;
    else if (cmd_mode)
      mode_word <= ADDR;
  end

  // ========================================================================
  // Bank state: open flags and active rows
  reg [1:0]          bank_open;
  reg [ROW_BITS-1:0] row0;
  reg [ROW_BITS-1:0] row1;

  // Precharge reach: one bank or both
  wire pre_b0 = cmd_pre && (a_ten || !a_bank);
  wire pre_b1 = cmd_pre && (a_ten || a_bank);

  // ========================================================================
  // Burst engine state
  reg                burst_on;
  reg                burst_wr;
  reg                burst_bank;
  reg [ROW_BITS-1:0] burst_row;
  reg [7:0]          burst_start;
  reg [7:0]          burst_step;
  reg [2:0]          burst_size;
  reg                burst_ilv;
  reg                burst_auto;
  reg [7:0]          len_m1;

  wire [7:0] cur_col;
  wire       pre_hit  = burst_bank ? pre_b1 : pre_b0;
  wire       cut      = cmd_rw || cmd_stop || pre_hit;
  wire       burst_fp = (burst_size == `SDRMB_BL_FP);

  // Last step index for the latched size
  always @*
  begin
    case (burst_size)
      `SDRMB_BL_2: len_m1 = 8'h01;
      `SDRMB_BL_4: len_m1 = 8'h03;
      `SDRMB_BL_8: len_m1 = 8'h07;
      default:     len_m1 = 8'h00;
    endcase
  end

  // Full page never ends on its own
  wire burst_last = !burst_fp && (burst_step == len_m1);
  wire auto_close = burst_on && burst_last && burst_auto && !cut;

  // Burst size used by a new command; single write mode forces one word on writes, reads keep the size
  wire [2:0] new_size = (cmd_wr && single_wr) ? `SDRMB_BL_1 : size_code;
  wire       new_one  = (new_size == `SDRMB_BL_1);
  // Single word write with auto close shuts its bank at once
  wire       wr_one_close = cmd_wr && new_one && a_ten;

  // Column generator for the current step
  sdrmb_burst_col u_col (
    .start      (burst_start),
    .step       (burst_step),
    .size_code  (burst_size),
    .interleave (burst_ilv),
    .col        (cur_col)
  );

  // Bank open flags and rows
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      bank_open <= 2'h0;
      row0      <= {ROW_BITS{1'b0}};
      row1      <= {ROW_BITS{1'b0}};
    end
    else
    begin
      if (cmd_act && !a_bank)
      begin
        bank_open[0] <= 1'b1;
        row0         <= ADDR[ROW_BITS-1:0];
      end
      else if (pre_b0 || (auto_close && !burst_bank) || (wr_one_close && !a_bank))
        bank_open[0] <= 1'b0;
      if (cmd_act && a_bank)
      begin
        bank_open[1] <= 1'b1;
        row1         <= ADDR[ROW_BITS-1:0];
      end
      else if (pre_b1 || (auto_close && burst_bank) || (wr_one_close && a_bank))
        bank_open[1] <= 1'b0;
    end
  end

  // Burst sequencing: new command wins, then stop, then stepping
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      burst_on    <= 1'b0;
      burst_wr    <= 1'b0;
      burst_bank  <= 1'b0;
      burst_row   <= {ROW_BITS{1'b0}};
      burst_start <= 8'h00;
      burst_step  <= 8'h00;
      burst_size  <= `SDRMB_BL_1;
      burst_ilv   <= 1'b0;
      burst_auto  <= 1'b0;
    end
    else if (cmd_rw)
    begin
      burst_wr    <= cmd_wr;
      burst_bank  <= a_bank;
      burst_row   <= a_bank ? row1 : row0;
      burst_start <= a_col;
      burst_size  <= new_size;
      burst_ilv   <= interleave;
      burst_auto  <= a_ten && (new_size != `SDRMB_BL_FP);
      // Write word 0 goes on this edge, so a write resumes at step 1
      burst_on    <= !(cmd_wr && new_one);
      burst_step  <= cmd_wr ? 8'h01 : 8'h00;
    end
    else if (cmd_stop || pre_hit)
      burst_on <= 1'b0;
    else if (burst_on)
    begin
      if (burst_last)
        burst_on <= 1'b0;
      else
        burst_step <= burst_step + 8'h01;
    end
  end

  // ========================================================================
  // Write path through the buffer
  wire             fifo_in_ready;
  wire             fifo_out_valid;
  wire [ENT_W-1:0] fifo_out_data;
  reg              drain_hold;
  reg  [15:0]      drop_cnt;

  // Command edge word uses the command address, later words the generator
  wire cont_wr   = burst_on && burst_wr && !cut;
  wire wr_push   = cmd_wr || cont_wr;
  wire [MEM_AW-1:0] cmd_waddr  = {a_bank, (a_bank ? row1 : row0), a_col};
  wire [MEM_AW-1:0] cont_waddr = {burst_bank, burst_row, cur_col};
  wire [ENT_W-1:0]  push_data  = {(cmd_wr ? cmd_waddr : cont_waddr), DQ_IN};
  wire wr_drop   = wr_push && !fifo_in_ready;
  wire drain     = fifo_out_valid && !drain_hold;

  assign WBUF_READY = fifo_in_ready;

  sdrmb_fifo #(
    .WIDTH (ENT_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (4)
  ) u_wbuf (
    .clk       (CLK),
    .rst       (RST),
    .in_valid  (wr_push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (fifo_out_valid),
    .out_ready (!drain_hold),
    .out_data  (fifo_out_data)
  );

  // ========================================================================
  // Storage array: both banks, all rows, all columns
  reg  [DATA_W-1:0] mem [0:(1<<MEM_AW)-1];
  wire [DATA_W-1:0] rd_word = mem[{burst_bank, burst_row, cur_col}];

  // Drained buffer entries land in the array
  always @(posedge CLK)
  begin
    if (drain)
      mem[fifo_out_data[ENT_W-1:DATA_W]] <= fifo_out_data[DATA_W-1:0];
  end

  // ========================================================================
  // Read pipeline: fetch one step per edge, delay by the latency
  wire              rd_fire = burst_on && !burst_wr && !cmd_stop && !pre_hit;
  reg               stage_v;
  reg  [DATA_W-1:0] stage_d;

  // Latency two drives the fetched word; three adds one stage
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      stage_v <= 1'b0;
      stage_d <= {DATA_W{1'b0}};
      DQ_OE   <= 1'b0;
      DQ_OUT  <= {DATA_W{1'b0}};
    end
    else
    begin
      stage_v <= rd_fire;
      stage_d <= rd_word;
      DQ_OE   <= lat3 ? stage_v : rd_fire;
      DQ_OUT  <= lat3 ? stage_d : rd_word;
    end
  end

  // ========================================================================
  // AHB-Lite register slave, zero wait states
  wire       ahb_take = HSEL && HTRANS[1] && HREADY;
  reg        wr_pend;
  reg  [7:0] wr_addr;
  reg  [31:0] rd_val;

  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  // Read value for an address phase
  always @*
  begin
    if (HADDR[7:0] == `SDRMB_REG_CTRL)
      rd_val = {31'h0, drain_hold};
    else if (HADDR[7:0] == `SDRMB_REG_MODE)
      rd_val = {20'h0, mode_word};
    else if (HADDR[7:0] == `SDRMB_REG_STAT)
      rd_val = {26'h0, !fifo_in_ready, fifo_out_valid, burst_wr, burst_on, bank_open};
    else if (HADDR[7:0] == `SDRMB_REG_DROP)
      rd_val = {16'h0, drop_cnt};
    else
      rd_val = 32'h0;
  end

  wire in_map = (HADDR[31:8] == 24'h0);
  wire clr_drop = wr_pend && (wr_addr == `SDRMB_REG_DROP);

  // Address phase capture, read data and register writes
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      wr_pend    <= 1'b0;
      wr_addr    <= 8'h00;
      HRDATA     <= 32'h0;
      drain_hold <= `SDRMB_CTRL_RST;
      drop_cnt   <= `SDRMB_DROP_RST;
    end
    else
    begin
      wr_pend <= ahb_take && HWRITE && in_map;
      wr_addr <= HADDR[7:0];
      if (ahb_take && !HWRITE)
        HRDATA <= in_map ? rd_val : 32'h0;
      if (wr_pend && (wr_addr == `SDRMB_REG_CTRL))
        drain_hold <= HWDATA[0];
      // A drop in the clearing cycle still counts
      if (wr_drop)
        drop_cnt <= clr_drop ? 16'h0001 : drop_cnt + 16'h0001;
      else if (clr_drop)
        drop_cnt <= `SDRMB_DROP_RST;
    end
  end

  // Transfer size is not decoded: every access is a whole word
  wire unused_ok = |HSIZE;

endmodule
`default_nettype wire

// *** verification/sdrmb_top_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sdrmb_consts.vh"

// ====================
// Port checker
module sdrmb_top_properties (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        CS_N,
  input wire logic        RAS_N,
  input wire logic        CAS_N,
  input wire logic        WE_N,
  input wire logic [11:0] ADDR,
  input wire logic        DQ_OE,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP
);
  logic [11:0] mode;
  wire  [2:0]  cmd = CS_N ? 3'h7 : {RAS_N, CAS_N, WE_N};
  wire         q   = (cmd == 3'h7);
  wire         rd  = (cmd == `SDRMB_CMD_READ);
  wire  [2:0]  bl  = mode[2:0];
  wire  [2:0]  cl  = mode[6:4];

  // Mirror of the opcode word
  always @(posedge CLK or posedge RST)
    if (RST)
      mode <= `SDRMB_MODE_RST;
    else if (cmd == `SDRMB_CMD_MODE)
      mode <= ADDR;

  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  property p_lat2;
    rd && cl == `SDRMB_CL_2 |-> ##2 DQ_OE;
  endproperty
  a_lat2: assert property (p_lat2) else $error("first word late at latency 2");
  property p_lat3;
    rd && cl == `SDRMB_CL_3 |-> ##3 DQ_OE;
  endproperty
  a_lat3: assert property (p_lat3) else $error("first word late at latency 3");
  property p_len4;
    rd && bl == `SDRMB_BL_4 && cl == `SDRMB_CL_2 ##1 q[*5] |-> DQ_OE ##1 !DQ_OE;
  endproperty
  a_len4: assert property (p_len4) else $error("burst of 4 wrong length");
  property p_len8;
    rd && bl == `SDRMB_BL_8 && cl == `SDRMB_CL_3 ##1 q[*8] ##1 q[*2] |-> DQ_OE ##1 !DQ_OE;
  endproperty
  a_len8: assert property (p_len8) else $error("burst of 8 wrong length");
  property p_page;
    rd && bl == `SDRMB_BL_FP ##1 q[*8] |-> DQ_OE;
  endproperty
  a_page: assert property (p_page) else $error("full page read ended early");
  property p_stop;
    cmd == `SDRMB_CMD_STOP ##1 q[*3] |-> !DQ_OE;
  endproperty
  a_stop: assert property (p_stop) else $error("words after burst stop");
  property p_mode;
    HSEL && HTRANS[1] && HREADY && !HWRITE && HADDR == {24'h0, `SDRMB_REG_MODE}
      |=> HRDATA == {20'h0, mode};
  endproperty
  a_mode: assert property (p_mode) else $error("opcode word not as loaded");
  property p_bus;
    HSEL && HTRANS[1] |=> HREADYOUT && !HRESP;
  endproperty
  a_bus: assert property (p_bus) else $error("bus wait or error response");
endmodule

bind sdrmb_top sdrmb_top_properties chk_u (
  .CLK(CLK), .RST(RST), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N),
  .ADDR(ADDR), .DQ_OE(DQ_OE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP)
);
`default_nettype wire

// *** verification/sdrmb_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sdrmb_consts.vh"

// ====================
// Memory controller model
module sdrmb_ctrl_model (
  input  wire logic        clk,
  output var  logic        cs_n,
  output var  logic        ras_n,
  output var  logic        cas_n,
  output var  logic        we_n,
  output var  logic [11:0] addr,
  output var  logic [15:0] dq
);
  // Deselected at time zero
  initial
  begin
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    addr = 12'h000;
    dq = 16'h0000;
  end

  // One command cycle, launched after the edge
  task issue(input logic [2:0] c, input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= c;
    addr <= a;
    dq <= d;
  endtask

  // Deselect; released lines show the inverse
  task idle(input int n);
    @(posedge clk);
    cs_n <= 1'b1;
    addr <= ~addr;
    dq <= ~dq;
    repeat (n - 1) @(posedge clk);
  endtask

  // Close both banks, load legal codes only, then two quiet cycles
  task load(input logic [2:0] b, input logic t, input logic [2:0] l, input logic [2:0] w);
    issue(`SDRMB_CMD_PRE, 12'h400, dq);
    issue(`SDRMB_CMD_MODE, {w, 2'h0, l, t, b}, dq);
    idle(2);
  endtask
endmodule
`default_nettype wire

// *** verification/sdrmb_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sdrmb_consts.vh"

// ====================
// Bench top
module sdrmb_top_tb;
  logic        clk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire  [31:0] hrdata;
  wire         hready;
  wire         hresp;
  wire         cs_n;
  wire         ras_n;
  wire         cas_n;
  wire         we_n;
  wire  [11:0] addr;
  wire  [15:0] dq_in;
  wire  [15:0] dq_out;
  wire         dq_oe;
  wire         wbuf_ready;
  int          err_total = 0;
  int          tests_run = 0;
  int          cyc = 0;
  logic [15:0] rq[$];

  sdrmb_top #(.ROW_BITS(4)) dut_u (
    .CLK(clk), .RST(rst), .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n),
    .ADDR(addr), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe), .WBUF_READY(wbuf_ready),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp)
  );
  sdrmb_ctrl_model ctl_u (
    .clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .addr(addr), .dq(dq_in)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Read word capture and hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (dq_oe === 1'b1)
      rq.push_back(dq_out);
    if (cyc == 20000)
    begin
      err_total = err_total + 1;
      close_out();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task close_out;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Single word transfer, waits on ready
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task rdreg(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask

  // Column of burst step k from start s, size n
  function automatic logic [7:0] colk(input logic [7:0] s, input int k, input int n,
                                      input logic bt);
    logic [7:0] m;
    m = 8'(n - 1);
    colk = (s & ~m) | ((bt ? (s ^ 8'(k)) : (s + 8'(k))) & m);
  endfunction

  // Write burst of c words, data b or column
  task wr(input logic [11:0] a, input int c, input int n, input logic [15:0] b);
    for (int k = 0; k < c; k++)
      ctl_u.issue(k == 0 ? `SDRMB_CMD_WRITE : 3'h7, a, b | colk(a[7:0], k, n, 1'b0));
  endtask

  // Read burst, optional stop, compare m words
  task rd(input logic [11:0] a, input int n, input logic bt, input logic [15:0] b,
          input logic stop, input int m);
    rq.delete();
    ctl_u.issue(`SDRMB_CMD_READ, a, 16'h0);
    ctl_u.idle(9);
    if (stop)
      ctl_u.issue(`SDRMB_CMD_STOP, 12'h0, 16'h0);
    ctl_u.idle(14);
    if (!stop)
      chk(rq.size(), n);
    for (int k = 0; k < m; k++)
      chk({16'h0, rq[k]}, b | colk(a[7:0], k, n, bt));
  endtask

  task t_regs;
    logic [31:0] r;
    rdreg(`SDRMB_REG_MODE, 32'h020);
    rdreg(`SDRMB_REG_DROP, 32'h0);
    ahb(1'b1, `SDRMB_REG_MODE, 32'hFFF, r);
    rdreg(`SDRMB_REG_MODE, 32'h020);
    ahb(1'b1, `SDRMB_REG_CTRL, 32'h1, r);
    rdreg(`SDRMB_REG_CTRL, 32'h1);
    ahb(1'b1, `SDRMB_REG_CTRL, 32'h0, r);
    rdreg(8'h10, 32'h0);
    // Upper address bits set: outside the map, reads zero, writes ignored
    rdreg(32'h00000104, 32'h0);
    ahb(1'b1, 32'h00000100, 32'h1, r);
    rdreg(`SDRMB_REG_CTRL, 32'h0);
    $display("test regs done");
  endtask

  task t_page;
    ctl_u.load(`SDRMB_BL_FP, 1'b0, `SDRMB_CL_3, `SDRMB_WM_BURST);
    ctl_u.issue(`SDRMB_CMD_ACT, 12'h001, 16'h0);
    wr(12'h000, 256, 256, 16'hA000);
    ctl_u.issue(`SDRMB_CMD_STOP, 12'h0, 16'h0);
    ctl_u.idle(30);
    rdreg(`SDRMB_REG_DROP, 32'h0);
    rd(12'h3FE, 256, 1'b0, 16'hA000, 1'b1, 4);
    $display("test page done");
  endtask

  task t_bursts;
    logic [2:0] bl[5] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h2};
    logic       bt[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [2:0] cl[5] = '{3'h2, 3'h2, 3'h3, 3'h3, 3'h2};
    logic [7:0] st[5] = '{8'h03, 8'h05, 8'h05, 8'h09, 8'h11};
    for (int i = 0; i < 5; i++)
    begin
      ctl_u.load(bl[i], bt[i], cl[i], `SDRMB_WM_BURST);
      ctl_u.issue(`SDRMB_CMD_ACT, 12'h001, 16'h0);
      rd({4'h0, st[i]}, 1 << bl[i], bt[i], 16'hA000, 1'b0, 1 << bl[i]);
    end
    $display("test bursts done");
  endtask

  task t_writes;
    ctl_u.load(`SDRMB_BL_4, 1'b0, `SDRMB_CL_2, `SDRMB_WM_BURST);
    ctl_u.issue(`SDRMB_CMD_ACT, 12'h802, 16'h0);
    wr(12'h830, 4, 4, 16'h5000);
    wr(12'hC21, 4, 4, 16'h5000);
    ctl_u.idle(20);
    // Banks closed; the last burst was a write, so its flag stays up
    rdreg(`SDRMB_REG_STAT, 32'h8);
    ctl_u.issue(`SDRMB_CMD_ACT, 12'h802, 16'h0);
    rd(12'h820, 4, 1'b0, 16'h5000, 1'b0, 4);
    ctl_u.issue(`SDRMB_CMD_ACT, 12'h001, 16'h0);
    rd(12'h020, 4, 1'b0, 16'hA000, 1'b0, 4);
    ctl_u.load(`SDRMB_BL_4, 1'b0, `SDRMB_CL_2, `SDRMB_WM_SINGLE);
    ctl_u.issue(`SDRMB_CMD_ACT, 12'h802, 16'h0);
    wr(12'h830, 4, 4, 16'h6000);
    ctl_u.idle(20);
    rd(12'h831, 4, 1'b0, 16'h5000, 1'b0, 3);
    chk({16'h0, rq[3]}, 32'h6030);
    ctl_u.issue(`SDRMB_CMD_ACT, 12'h001, 16'h0);
    rdreg(`SDRMB_REG_STAT, 32'h3);
    ctl_u.issue(`SDRMB_CMD_PRE, 12'h800, 16'h0);
    rdreg(`SDRMB_REG_STAT, 32'h1);
    ctl_u.issue(`SDRMB_CMD_PRE, 12'h400, 16'h0);
    rdreg(`SDRMB_REG_STAT, 32'h0);
    // Single word write with auto close shuts its bank at once
    ctl_u.issue(`SDRMB_CMD_ACT, 12'h802, 16'h0);
    wr(12'hC32, 1, 4, 16'h6000);
    ctl_u.idle(2);
    rdreg(`SDRMB_REG_STAT, 32'h8);
    $display("test writes done");
  endtask

  task t_buf;
    logic [31:0] r;
    ahb(1'b1, `SDRMB_REG_CTRL, 32'h1, r);
    ctl_u.load(`SDRMB_BL_FP, 1'b0, `SDRMB_CL_2, `SDRMB_WM_BURST);
    ctl_u.issue(`SDRMB_CMD_ACT, 12'h001, 16'h0);
    wr(12'h040, 18, 256, 16'hC000);
    ctl_u.issue(`SDRMB_CMD_STOP, 12'h0, 16'h0);
    ctl_u.idle(2);
    #1;
    chk({31'h0, wbuf_ready}, 32'h0);
    rdreg(`SDRMB_REG_STAT, 32'h39);
    rdreg(`SDRMB_REG_DROP, 32'h2);
    ahb(1'b1, `SDRMB_REG_DROP, 32'h0, r);
    rdreg(`SDRMB_REG_DROP, 32'h0);
    ahb(1'b1, `SDRMB_REG_CTRL, 32'h0, r);
    ctl_u.idle(40);
    rdreg(`SDRMB_REG_STAT, 32'h9);
    rd(12'h04C, 256, 1'b0, 16'hC000, 1'b1, 4);
    $display("test buffer done");
  endtask

  // Reset, then the scenarios in turn
  initial
  begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_page();
    t_bursts();
    t_writes();
    t_buf();
    close_out();
  end
endmodule
`default_nettype wire
